// ---- rtl/fpec_pkg.sv ----
// package: register map, field positions, timing constants and types for the flash control block
package fpec_pkg;

	// ********************
	// register map
	// ********************
	localparam logic [7:0] FPEC_OFF_CTRL    = 8'h00;
	localparam logic [7:0] FPEC_OFF_PROTECT = 8'h04;
	localparam logic [7:0] FPEC_OFF_STATUS  = 8'h08;
	localparam logic [7:0] FPEC_OFF_ADDR    = 8'h0c;
	localparam logic [7:0] FPEC_OFF_WDATA   = 8'h10;
	localparam logic [7:0] FPEC_OFF_RDATA   = 8'h14;

	// control bit positions
	localparam int FPEC_BIT_ROW   = 0;
	localparam int FPEC_BIT_WIPE  = 1;
	localparam int FPEC_BIT_WHOLE = 2;
	localparam int FPEC_BIT_PUMP  = 3;

	localparam logic [7:0]  FPEC_CTRL_RESET    = 8'h00;
	localparam logic [7:0]  FPEC_PROTECT_OPEN  = 8'hff;
	localparam logic [7:0]  FPEC_PROTECT_RESET = 8'hff;
	localparam logic [7:0]  FPEC_ERASED_BYTE   = 8'hff;
	localparam logic [1:0]  FPEC_AXI_OKAY      = 2'b00;
	localparam logic [1:0]  FPEC_AXI_SLVERR    = 2'b10;

	// ********************
	// array geometry
	// ********************
	localparam int          FPEC_AW        = 16;
	localparam logic [15:0] FPEC_ARR_LO    = 16'hee00;
	localparam logic [15:0] FPEC_VEC_LO    = 16'hffd0;
	localparam logic [15:0] FPEC_TRIM_LO   = 16'hffc0;
	localparam logic [15:0] FPEC_TRIM_HI   = 16'hffc1;
	localparam logic [15:0] FPEC_PAGE_MASK = 16'hffc0;
	localparam logic [15:0] FPEC_ROW_MASK  = 16'hffe0;
	localparam logic [1:0]  FPEC_PROT_TOP  = 2'b11;
	localparam logic [5:0]  FPEC_PROT_LOW  = 6'h00;
	localparam int          FPEC_MEM_DEPTH = 65536;

	// ********************
	// timing
	// ********************
	localparam int FPEC_CLK_KHZ     = 25000;
	localparam int FPEC_SETUP_US    = 10;
	localparam int FPEC_PUMP_SU_US  = 5;
	localparam int FPEC_HOLD_US     = 5;
	localparam int FPEC_LONG_HOLD_US = 100;
	localparam int FPEC_RECOVER_US  = 1;
	localparam int FPEC_SETUP_CYC   = (FPEC_SETUP_US * FPEC_CLK_KHZ + 999) / 1000;
	localparam int FPEC_PUMP_SU_CYC = (FPEC_PUMP_SU_US * FPEC_CLK_KHZ + 999) / 1000;
	localparam int FPEC_HOLD_CYC    = (FPEC_HOLD_US * FPEC_CLK_KHZ + 999) / 1000;
	localparam int FPEC_LHOLD_CYC   = (FPEC_LONG_HOLD_US * FPEC_CLK_KHZ + 999) / 1000;
	localparam int FPEC_RECOVER_CYC = (FPEC_RECOVER_US * FPEC_CLK_KHZ + 999) / 1000;
	localparam int FPEC_CNT_W       = 20;

	typedef enum logic [2:0] {
		FPEC_ST_IDLE,
		FPEC_ST_ARMED,
		FPEC_ST_PUMPING,
		FPEC_ST_HOLD,
		FPEC_ST_RECOVER
	} fpec_state_type;

	typedef struct packed {
		logic        en;
		logic        we;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} fpec_mem_req_type;

endpackage

// ---- rtl/fpec_array.sv ----
// byte-wide nonvolatile array model with registered read data
module fpec_array
	import fpec_pkg::*;
(
	// clock
	input  wire logic             ref_clk_in,
	// access
	input  wire fpec_mem_req_type req_in,
	output logic [7:0]            rdata_out
);

	logic [7:0] mem_r [FPEC_MEM_DEPTH];

	// no reset on the array: contents survive reset like the real cells
	always_ff @(posedge ref_clk_in) begin
		if (req_in.en && req_in.we) begin
			mem_r[req_in.addr] <= req_in.wdata;
		end
		if (req_in.en) begin
			rdata_out <= mem_r[req_in.addr];
		end
	end

endmodule

// ---- rtl/fpec_ctrl.sv ----
// flash program/erase control block with AXI4-Lite register slave
// Function
// R01: whole-array select bit, read/write, selects mass erase when one.
// R02: block-wipe and row-write selects interlocked; never both one.
// R03: page erase clears 64 aligned bytes, or the 48-byte vector page.
// R04: software: wipe select, read protect, latch write, wait 10 us, pump on.
// R05: software: hold pump 1 or 4 ms, drop wipe, wait 5 us, pump off.
// R06: software: prefer 4 ms page wipe above 1000 cycles.
// R07: vector page or mass erase also wipes both trim bytes.
// R08: software mass erase sequence with 4 ms hold and 100 us release.
// R09: mass erase disabled unless protect byte is all ones; whole-array set with pump in one write is checked on the latched address.
// R10: software: monitor mode latch write goes to protect byte.
// R11: programming works on aligned 32-byte rows, one row per sequence.
// R12: software programs only bytes currently erased.
// R13: row-write select enables latching; pump needs 10 us setup.
// R14: software: 30 us after each byte write.
// R15: software: address change interval stays under max byte time.
// R16: pump off after 5 us hold; array readable after 1 us recovery.
// R17: software must not write watchdog address while pump is on.
// R18: software: no self-programming; steps keep their order.
// R19: protect from derived start to top; refuse pump when target protected.
// R20: software reads protect byte between select and pump enable.
// R21: protect zero locks all; all ones leaves all open.
// R22: protect byte locked once not all ones unless test voltage present; here reset also reloads all ones.
// R23: pump bit settable only with a select set and proper sequence.
// R24: protect byte supplies address bits 13..6; top ones, bottom zeros.
// R25: delays counted in bus-clock cycles set by parameters.
module fpec_ctrl
	import fpec_pkg::*;
(
	// clock and reset
	input  wire logic        ref_clk_in,
	input  wire logic        rst_b_in,
	// pin
	input  wire logic        test_high_voltage_in,
	// axi4-lite write
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	// status
	output logic             pump_voltage_on_out
);

	// ********************
	// page and mass erase time parameters
	// ********************
	localparam int PAGE_WIPE_US  = 1000;
	localparam int ARRAY_WIPE_US = 4000;
	localparam int PAGE_WIPE_CYC  = PAGE_WIPE_US * (FPEC_CLK_KHZ / 1000);   // [R25]
	localparam int ARRAY_WIPE_CYC = ARRAY_WIPE_US * (FPEC_CLK_KHZ / 1000);  // [R25]

	logic [7:0]           ctrl_r;
	logic [7:0]           protect_r;
	logic                 prot_read_r;
	logic                 latched_r;
	logic [15:0]          lat_addr_r;
	logic [15:0]          addr_r;
	logic [7:0]           wdata_r;
	logic                 refused_r;
	logic                 busy_r;
	logic [FPEC_CNT_W-1:0] cnt_r;
	fpec_state_type       state_r;
	logic [15:0]          wipe_ptr_r;
	logic                 wiping_r;
	logic                 wipe_done_r;
	logic                 is_mass_r;
	logic                 tv_s1_r;
	logic                 tv_s2_r;
	fpec_mem_req_type     mreq;
	logic [7:0]           mem_q;

	logic       aw_hold_r;
	logic       w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	wire row_sel   = ctrl_r[FPEC_BIT_ROW];
	wire wipe_sel  = ctrl_r[FPEC_BIT_WIPE];
	wire whole_sel = ctrl_r[FPEC_BIT_WHOLE];
	wire pump_on   = ctrl_r[FPEC_BIT_PUMP];

	// ********************
	// protection decode
	// ********************
	function automatic logic [15:0] prot_start(input logic [7:0] pb);
		prot_start = {FPEC_PROT_TOP, pb, FPEC_PROT_LOW};  // [R24]
	endfunction

	// start at or below the array base protects everything; all ones opens all
	function automatic logic is_protected(input logic [7:0] pb, input logic [15:0] a);
		if (pb == FPEC_PROTECT_OPEN)
			is_protected = 1'b0;                                          // [R21]
		else
			is_protected = (a >= prot_start(pb)) || (prot_start(pb) <= FPEC_ARR_LO); // [R19] [R21]
	endfunction

	// ********************
	// test voltage synchroniser
	// ********************
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			tv_s1_r <= 1'b0;
			tv_s2_r <= 1'b0;
		end else begin
			tv_s1_r <= test_high_voltage_in;
			tv_s2_r <= tv_s1_r;
		end
	end

	// ********************
	// axi write channel capture
	// ********************
	wire do_write = aw_hold_r && w_hold_r && !s_axi_bvalid_out;
	wire aw_dec_ctrl  = (aw_addr_r == FPEC_OFF_CTRL);
	wire aw_dec_prot  = (aw_addr_r == FPEC_OFF_PROTECT);
	wire aw_dec_addr  = (aw_addr_r == FPEC_OFF_ADDR);
	wire aw_dec_wdata = (aw_addr_r == FPEC_OFF_WDATA);
	wire aw_known = aw_dec_ctrl || aw_dec_prot || aw_dec_addr || aw_dec_wdata
		|| (aw_addr_r == FPEC_OFF_STATUS) || (aw_addr_r == FPEC_OFF_RDATA);

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_hold_r         <= 1'b0;
			w_hold_r          <= 1'b0;
			aw_addr_r         <= 8'h00;
			w_data_r          <= 32'h0000_0000;
			w_strb_r          <= 4'h0;
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out  <= 1'b1;
			s_axi_bvalid_out  <= 1'b0;
			s_axi_bresp_out   <= FPEC_AXI_OKAY;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_hold_r         <= 1'b1;
				aw_addr_r         <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_hold_r         <= 1'b1;
				w_data_r         <= s_axi_wdata_in;
				w_strb_r         <= s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= aw_known ? FPEC_AXI_OKAY : FPEC_AXI_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out  <= 1'b0;
				aw_hold_r         <= 1'b0;
				w_hold_r          <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out  <= 1'b1;
			end
		end
	end

	wire wr_lane0 = do_write && w_strb_r[0];
	wire [7:0] wb = w_data_r[7:0];

	// ********************
	// control register with interlock and pump gating
	// ********************
	wire target_prot = whole_sel ? (protect_r != FPEC_PROTECT_OPEN)          // [R09]
	                             : is_protected(protect_r, lat_addr_r);     // [R19]
	wire pump_ok = (row_sel || wipe_sel) && prot_read_r && latched_r        // [R23]
		&& (state_r == FPEC_ST_ARMED) && (cnt_r == '0) && !target_prot;   // [R19]

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ctrl_r <= FPEC_CTRL_RESET;
		end else if (wr_lane0 && aw_dec_ctrl) begin
			ctrl_r[FPEC_BIT_WHOLE] <= wb[FPEC_BIT_WHOLE];                       // [R01]
			// a write asking for both selects leaves them as they were; one asking for the other while one is set clears both
			if (!(wb[FPEC_BIT_ROW] && wb[FPEC_BIT_WIPE])) begin                 // [R02]
				ctrl_r[FPEC_BIT_ROW]  <= wb[FPEC_BIT_ROW] && !wipe_sel;         // [R02]
				ctrl_r[FPEC_BIT_WIPE] <= wb[FPEC_BIT_WIPE] && !row_sel;         // [R02]
			end
			if (!wb[FPEC_BIT_PUMP])
				ctrl_r[FPEC_BIT_PUMP] <= 1'b0;
			else if (!pump_on)
				ctrl_r[FPEC_BIT_PUMP] <= pump_ok;                               // [R23]
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			refused_r <= 1'b0;
		else if (wr_lane0 && aw_dec_ctrl && wb[FPEC_BIT_PUMP] && !pump_on && !pump_ok)
			refused_r <= 1'b1;
		else if (wr_lane0 && aw_dec_ctrl && !wb[FPEC_BIT_PUMP])
			refused_r <= 1'b0;
	end

	// ********************
	// array access: address, data and latch
	// ********************
	wire arr_wr = wr_lane0 && aw_dec_wdata;
	wire wipe_active = !whole_sel && wipe_sel;

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			addr_r      <= 16'h0000;
			wdata_r     <= 8'h00;
			latched_r   <= 1'b0;
			lat_addr_r  <= 16'h0000;
			prot_read_r <= 1'b0;
		end else begin
			if (do_write && aw_dec_addr && w_strb_r[0])
				addr_r[7:0] <= w_data_r[7:0];
			if (do_write && aw_dec_addr && w_strb_r[1])
				addr_r[15:8] <= w_data_r[15:8];
			if (arr_wr)
				wdata_r <= wb;
			if (!row_sel && !wipe_sel) begin
				latched_r   <= 1'b0;
				prot_read_r <= 1'b0;
			end else begin
				if (s_axi_arvalid_in && s_axi_arready_out
					&& s_axi_araddr_in == FPEC_OFF_PROTECT)
					prot_read_r <= 1'b1;                                        // [R20]
				if (arr_wr && !latched_r && prot_read_r) begin
					latched_r  <= 1'b1;                                         // [R13]
					lat_addr_r <= addr_r;
				end
			end
		end
	end

	// ********************
	// protect byte
	// ********************
	// lives in the array in silicon; here a register, reset to all ones, that otherwise only changes while all ones or under test voltage
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			protect_r <= FPEC_PROTECT_RESET;
		else if (wr_lane0 && aw_dec_prot && (tv_s2_r || protect_r == FPEC_PROTECT_OPEN))
			protect_r <= wb;                                                    // [R22]
	end

	// ********************
	// sequence timer
	// ********************
	wire [FPEC_CNT_W-1:0] setup_cnt = FPEC_CNT_W'(FPEC_SETUP_CYC);
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= FPEC_ST_IDLE;
			cnt_r   <= '0;
			busy_r  <= 1'b0;
		end else begin
			if (cnt_r != '0)
				cnt_r <= cnt_r - 1'b1;                                         // [R25]
			case (state_r)
				FPEC_ST_IDLE: begin
					if (arr_wr && (row_sel || wipe_sel) && prot_read_r && !latched_r) begin
						state_r <= FPEC_ST_ARMED;
						cnt_r   <= setup_cnt;                                   // [R13]
					end
				end
				FPEC_ST_ARMED: begin
					busy_r <= 1'b0;
					if (pump_on) begin
						state_r <= FPEC_ST_PUMPING;
						busy_r  <= 1'b1;
						cnt_r   <= FPEC_CNT_W'(row_sel ? FPEC_PUMP_SU_CYC
							: (whole_sel ? ARRAY_WIPE_CYC : PAGE_WIPE_CYC));
					end else if (!row_sel && !wipe_sel)
						state_r <= FPEC_ST_IDLE;
				end
				FPEC_ST_PUMPING: begin
					if (!row_sel && !wipe_sel) begin
						state_r <= FPEC_ST_HOLD;
						cnt_r   <= FPEC_CNT_W'(is_mass_r ? FPEC_LHOLD_CYC : FPEC_HOLD_CYC);
					end
				end
				FPEC_ST_HOLD: begin
					if (!pump_on) begin
						state_r <= FPEC_ST_RECOVER;
						cnt_r   <= FPEC_CNT_W'(FPEC_RECOVER_CYC);               // [R16]
					end
				end
				FPEC_ST_RECOVER: begin
					if (cnt_r == '0) begin
						state_r <= FPEC_ST_IDLE;
						busy_r  <= 1'b0;                                        // [R16]
					end
				end
				default: state_r <= FPEC_ST_IDLE;
			endcase
		end
	end

	// ********************
	// erase walker and row programming
	// ********************
	wire prog_hit = arr_wr && row_sel && pump_on && (state_r == FPEC_ST_PUMPING)
		&& ((addr_r & FPEC_ROW_MASK) == (lat_addr_r & FPEC_ROW_MASK))   // [R11]
		&& !is_protected(protect_r, addr_r);                               // [R19]
	wire [15:0] page_base = (lat_addr_r >= FPEC_VEC_LO) ? FPEC_TRIM_LO
		: (lat_addr_r & FPEC_PAGE_MASK);                                    // [R03]

	// erase applied while still pumping, once the wipe time has run
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wiping_r    <= 1'b0;
			wipe_ptr_r  <= 16'h0000;
			wipe_done_r <= 1'b0;
			is_mass_r   <= 1'b0;
		end else begin
			if (state_r == FPEC_ST_ARMED && pump_on) begin
				is_mass_r   <= whole_sel && wipe_sel;
				wipe_done_r <= 1'b0;
			end
			if (state_r == FPEC_ST_PUMPING && !wiping_r && !wipe_done_r
				&& (wipe_sel || is_mass_r) && cnt_r == '0) begin
				wiping_r    <= 1'b1;
				wipe_ptr_r  <= is_mass_r ? FPEC_ARR_LO : page_base;            // [R03]
			end else if (wiping_r) begin
				wipe_ptr_r <= wipe_ptr_r + 16'h0001;
				// page ends at next 64-byte boundary; vector page and mass end at top
				if (wipe_ptr_r == 16'hffff
					|| (!is_mass_r && wipe_ptr_r < FPEC_VEC_LO
					&& (wipe_ptr_r & ~FPEC_PAGE_MASK) == ~FPEC_PAGE_MASK)) begin
					wiping_r    <= 1'b0;
					wipe_done_r <= 1'b1;
				end
			end
		end
	end
	// vector wipe starts at the trim bytes so they go with it, as mass erase does [R07]

	always_comb begin
		mreq.en    = 1'b1;
		mreq.we    = 1'b0;
		mreq.addr  = addr_r;
		mreq.wdata = wdata_r;
		if (wiping_r) begin
			mreq.we    = 1'b1;
			mreq.addr  = wipe_ptr_r;
			mreq.wdata = FPEC_ERASED_BYTE;                                     // [R07]
		end else if (prog_hit) begin
			mreq.we    = 1'b1;
			mreq.wdata = wb & mem_q;                                           // [R11]
		end
	end

	fpec_array u_array (
		.ref_clk_in (ref_clk_in),
		.req_in     (mreq),
		.rdata_out  (mem_q)
	);

	// ********************
	// axi read channel
	// ********************
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out  <= 1'b0;
			s_axi_rdata_out   <= 32'h0000_0000;
			s_axi_rresp_out   <= FPEC_AXI_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out  <= 1'b1;
			s_axi_rresp_out   <= FPEC_AXI_OKAY;
			case (s_axi_araddr_in)
				FPEC_OFF_CTRL:    s_axi_rdata_out <= {24'h000000, ctrl_r};
				FPEC_OFF_PROTECT: s_axi_rdata_out <= {24'h000000, protect_r};
				FPEC_OFF_STATUS:  s_axi_rdata_out <= {24'h000000, 3'b000, wiping_r,
					refused_r, latched_r, prot_read_r, busy_r};
				FPEC_OFF_ADDR:    s_axi_rdata_out <= {16'h0000, addr_r};
				FPEC_OFF_WDATA:   s_axi_rdata_out <= {24'h000000, wdata_r};
				FPEC_OFF_RDATA:   s_axi_rdata_out <= {24'h000000, mem_q};
				default: begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= FPEC_AXI_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out  <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			pump_voltage_on_out <= 1'b0;
		else
			pump_voltage_on_out <= pump_on;
	end

endmodule

// ---- tb/fpec_cpu_model.sv ----
// cpu-side axi4-lite master that issues the control sequences
module fpec_cpu_model
	import fpec_pkg::*;
(
	// clock
	input  wire logic        ref_clk_in,
	// write channels
	output logic [7:0]       awaddr_out,
	output logic             awvalid_out,
	input  wire logic        awready_in,
	output logic [31:0]      wdata_out,
	output logic [3:0]       wstrb_out,
	output logic             wvalid_out,
	input  wire logic        wready_in,
	input  wire logic [1:0]  bresp_in,
	input  wire logic        bvalid_in,
	output logic             bready_out,
	// read channels
	output logic [7:0]       araddr_out,
	output logic             arvalid_out,
	input  wire logic        arready_in,
	input  wire logic [31:0] rdata_in,
	input  wire logic [1:0]  rresp_in,
	input  wire logic        rvalid_in,
	output logic             rready_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int n_hang = 0;
	initial begin
		{awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
		{araddr_out, arvalid_out, rready_out} = '0;
		wstrb_out = 4'hf;
	end
	// each step completes before the next is issued
	// no monitor mode, latch writes hit the array; top address untouched
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_in);
		awaddr_out <= a;
		wdata_out <= d;
		awvalid_out <= 1'b1;
		wvalid_out <= 1'b1;
		bready_out <= 1'b1;
		repeat (64) begin
			@(posedge ref_clk_in);
			if (awready_in)
				awvalid_out <= 1'b0;
			if (wready_in)
				wvalid_out <= 1'b0;
			if (bvalid_in) begin
				r = bresp_in;
				bready_out <= 1'b0;
				return;
			end
		end
		n_hang++;
		tb_flash_program_erase_control.report_and_stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge ref_clk_in);
		araddr_out <= a;
		arvalid_out <= 1'b1;
		rready_out <= 1'b1;
		repeat (64) begin
			@(posedge ref_clk_in);
			if (arready_in)
				arvalid_out <= 1'b0;
			if (rvalid_in) begin
				d = rdata_in;
				r = rresp_in;
				rready_out <= 1'b0;
				return;
			end
		end
		n_hang++;
		tb_flash_program_erase_control.report_and_stop();
	endtask
endmodule

// ---- tb/fpec_ctrl_asserts.sv ----
// port checks for the flash control block
module fpec_ctrl_chk
	import fpec_pkg::*;
(
	input wire logic        ref_clk_in,
	input wire logic        rst_b_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic [7:0]  s_axi_araddr_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in,
	input wire logic        pump_voltage_on_out
);
	logic [8:0] up_r;
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (!rst_b_in);
	// saturates: only needs to reach the setup count
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in)
			up_r <= 9'h000;
		else if (up_r != 9'h1ff)
			up_r <= up_r + 9'h001;
	end
	a_b_stands: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
		else $error("write response dropped early");
	a_r_stands: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data unstable");
	a_r_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
		else $error("read not answered");
	a_w_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("write not answered");
	a_w_blocked: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
		else $error("write taken while response pending");
	a_ar_blocked: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
		else $error("read taken while data pending");
	a_unmapped_err: assert property (s_axi_arvalid_in && s_axi_arready_out
		&& s_axi_araddr_in > FPEC_OFF_RDATA |=> s_axi_rresp_out == FPEC_AXI_SLVERR)
		else $error("unmapped read not refused");
	a_mapped_okay: assert property (s_axi_arvalid_in && s_axi_arready_out
		&& s_axi_araddr_in <= FPEC_OFF_RDATA && s_axi_araddr_in[1:0] == 2'b00
		|=> s_axi_rresp_out == FPEC_AXI_OKAY)
		else $error("mapped read refused");
	a_pump_setup: assert property (up_r < FPEC_SETUP_CYC |-> !pump_voltage_on_out)
		else $error("pump on before setup time");
	a_pump_rest: assert property ($fell(pump_voltage_on_out) |=> !pump_voltage_on_out [*8])
		else $error("pump back on without new setup");
endmodule
bind fpec_ctrl fpec_ctrl_chk u_chk (
	.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .s_axi_awvalid_in(s_axi_awvalid_in),
	.s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
	.s_axi_wready_out(s_axi_wready_out), .s_axi_bvalid_out(s_axi_bvalid_out),
	.s_axi_bready_in(s_axi_bready_in), .s_axi_araddr_in(s_axi_araddr_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
	.pump_voltage_on_out(pump_voltage_on_out)
);

// ---- tb/tb_flash_program_erase_control.sv ----
// self-checking bench for the flash program and erase control block
module tb_flash_program_erase_control
	import fpec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ALL = 32'hffffffff;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        tv = 1'b0;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d2;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, r2;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, pump;
	int          n_mismatch = 0;
	int          samples_checked = 0;
	always #20 ref_clk = ~ref_clk;
	fpec_ctrl u_dut (
		.ref_clk_in(ref_clk), .rst_b_in(rst_b), .test_high_voltage_in(tv),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .pump_voltage_on_out(pump)
	);
	fpec_cpu_model u_cpu (
		.ref_clk_in(ref_clk), .awaddr_out(awaddr), .awvalid_out(awvalid),
		.awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb), .wvalid_out(wvalid),
		.wready_in(wready), .bresp_in(bresp), .bvalid_in(bvalid), .bready_out(bready),
		.araddr_out(araddr), .arvalid_out(arvalid), .arready_in(arready),
		.rdata_in(rdata), .rresp_in(rresp), .rvalid_in(rvalid), .rready_out(rready)
	);
	task automatic report_and_stop();
		n_mismatch += u_cpu.n_hang;
		$display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wc(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		u_cpu.wr(a, d, r);
		chk({30'h0, r}, {30'h0, FPEC_AXI_OKAY});
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		u_cpu.rd(a, d, r);
		chk(d & m, e);
	endtask
	// array read goes through the address register, two cycles to settle
	task automatic arr(input logic [15:0] a, input logic [7:0] e);
		wc(FPEC_OFF_ADDR, {16'h0, a});
		wt(2);
		rc(FPEC_OFF_RDATA, ALL, {24'h0, e});
	endtask
	task automatic arm(input logic [3:0] sel, input logic [15:0] a, input int w, input logic ok);
		wc(FPEC_OFF_CTRL, {28'h0, sel});
		rc(FPEC_OFF_PROTECT, 32'h0, 32'h0);
		wc(FPEC_OFF_ADDR, {16'h0, a});
		wc(FPEC_OFF_WDATA, 32'hff);
		wt(w);
		wc(FPEC_OFF_CTRL, {28'h0, sel | 4'h8});
		rc(FPEC_OFF_CTRL, 32'h8, {28'h0, ok, 3'h0});
		chk({31'h0, pump}, {31'h0, ok});
	endtask
	task automatic stop_op();
		wc(FPEC_OFF_CTRL, 32'h8);
		wt(FPEC_HOLD_CYC + 5);
		wc(FPEC_OFF_CTRL, 32'h0);
		wt(FPEC_RECOVER_CYC + 5);
		rc(FPEC_OFF_STATUS, 32'h1, 32'h0);
	endtask
	task automatic erase(input logic [15:0] a);
		arm(4'h2, a, FPEC_SETUP_CYC + 10, 1'b1);
		rc(FPEC_OFF_STATUS, 32'h1, 32'h1);
		wt(FPEC_CLK_KHZ + 100);
		stop_op();
	endtask
	initial begin
		wt(5);
		rst_b <= 1'b1;
		rc(FPEC_OFF_CTRL, ALL, 32'h0);
		rc(FPEC_OFF_PROTECT, ALL, 32'hff);
		wc(FPEC_OFF_CTRL, 32'h3);
		rc(FPEC_OFF_CTRL, ALL, 32'h0);
		wc(FPEC_OFF_CTRL, 32'h2);
		wc(FPEC_OFF_CTRL, 32'h3);
		rc(FPEC_OFF_CTRL, ALL, 32'h2);
		wc(FPEC_OFF_CTRL, 32'h6);
		rc(FPEC_OFF_CTRL, ALL, 32'h6);
		wc(FPEC_OFF_CTRL, 32'h0);
		arm(4'h1, 16'hf000, 0, 1'b0);
		rc(FPEC_OFF_STATUS, 32'h8, 32'h8);
		wc(FPEC_OFF_CTRL, 32'h0);
		erase(16'hf000);
		arr(16'hf000, 8'hff);
		arr(16'hf03f, 8'hff);
		erase(16'hffe5);
		arr(16'hffc0, 8'hff);
		arr(16'hffc1, 8'hff);
		arr(16'hffff, 8'hff);
		// two bytes in one row, then one past it that must not land
		arm(4'h1, 16'hf000, FPEC_SETUP_CYC + 10, 1'b1);
		wt(FPEC_PUMP_SU_CYC + 5);
		wc(FPEC_OFF_WDATA, 32'h5a);
		wt(760);
		wc(FPEC_OFF_ADDR, 32'hf01f);
		wc(FPEC_OFF_WDATA, 32'h0f);
		wt(760);
		wc(FPEC_OFF_ADDR, 32'hf020);
		wc(FPEC_OFF_WDATA, 32'h00);
		stop_op();
		arr(16'hf000, 8'h5a);
		arr(16'hf01f, 8'h0f);
		arr(16'hf020, 8'hff);
		arr(16'hf001, 8'hff);
		wc(FPEC_OFF_PROTECT, 32'hfe);
		rc(FPEC_OFF_PROTECT, ALL, 32'hfe);
		arm(4'h6, 16'hf000, FPEC_SETUP_CYC + 10, 1'b0);
		stop_op();
		arm(4'h1, 16'hffd0, FPEC_SETUP_CYC + 10, 1'b0);
		stop_op();
		arm(4'h1, 16'hfdff, FPEC_SETUP_CYC + 10, 1'b1);
		stop_op();
		wc(FPEC_OFF_PROTECT, 32'hff);
		rc(FPEC_OFF_PROTECT, ALL, 32'hfe);
		tv <= 1'b1;
		wt(4);
		wc(FPEC_OFF_PROTECT, 32'h00);
		rc(FPEC_OFF_PROTECT, ALL, 32'h00);
		tv <= 1'b0;
		arm(4'h1, 16'hee00, FPEC_SETUP_CYC + 10, 1'b0);
		stop_op();
		u_cpu.wr(8'h18, 32'h0, r2);
		chk({30'h0, r2}, {30'h0, FPEC_AXI_SLVERR});
		u_cpu.rd(8'h18, d2, r2);
		chk({30'h0, r2}, {30'h0, FPEC_AXI_SLVERR});
		report_and_stop();
	end
endmodule
